// >>> rtl/flash_seq_pkg.sv
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 14;
  localparam int WORD_W    = 14;
  localparam int ROW_W     = 5;
  localparam int ROW_WORDS = 32;
  localparam int HIGH_W    = 6;
  localparam int LOW_W     = 8;
  localparam int SRC_N     = 4;
  localparam logic [WORD_W-1:0] WORD_ERASED = 14'h3fff;
  localparam logic [ROW_W-1:0]  ROW_LAST    = 5'h1f;
  localparam logic [ADDR_W-1:0] ADDR_LAST   = 14'h3fff;

  // ----------------------------------------------------------------
  // Configuration word: erased state is unprotected
  // ----------------------------------------------------------------
  localparam int CFG_W       = 4;
  localparam int CFG_CODE_LOCK_BIT = 0;
  localparam int CFG_DATA_LOCK_BIT = 1;
  localparam int CFG_WPROT_LSB     = 2;
  localparam logic [CFG_W-1:0]  CFG_ERASED     = 4'hf;
  localparam logic [1:0]        WP_ALL         = 2'h0;
  localparam logic [1:0]        WP_HALF        = 2'h1;
  localparam logic [1:0]        WP_QUARTER     = 2'h2;
  localparam logic [1:0]        WP_OFF         = 2'h3;
  localparam logic [ADDR_W-1:0] WP_QUARTER_END = 14'h1000;
  localparam logic [ADDR_W-1:0] WP_HALF_END    = 14'h2000;

  // ----------------------------------------------------------------
  // Operation timing, least times rounded up to cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERASE_TIME_NS = 2000;
  localparam int WRITE_TIME_NS = 1000;
  localparam int TIMER_W       = 16;
  localparam logic [TIMER_W-1:0] ERASE_CYCLES = TIMER_W'(
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] WRITE_CYCLES = TIMER_W'(
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Read source index, also the fixed read priority (low wins)
  localparam int SRC_PGM   = 0;
  localparam int SRC_NVM   = 1;
  localparam int SRC_IND   = 2;
  localparam int SRC_FETCH = 3;

  typedef enum {S_IDLE, S_TIME, S_WORK} seq_state_e;
  typedef enum logic [1:0] {OP_ERASE, OP_PROG, OP_WORD, OP_BULK} op_e;

endpackage : flash_seq_pkg

// >>> rtl/flash_array.sv
`timescale 1ns/1ns
`default_nettype none

module flash_array
  import flash_seq_pkg::*;
(
  input  wire logic              clock_in,    // System clock
  input  wire logic              rd_en_in,    // Read strobe
  input  wire logic [ADDR_W-1:0] rd_addr_in,  // Read word address
  output logic      [WORD_W-1:0] rd_data_out, // Registered read word
  input  wire logic              wr_en_in,    // Write strobe
  input  wire logic              wr_erase_in, // Erase instead of program
  input  wire logic [ADDR_W-1:0] wr_addr_in,  // Write word address
  input  wire logic [WORD_W-1:0] wr_data_in   // Program data
);

  logic [WORD_W-1:0] mem [2**ADDR_W];

  // ----------------------------------------------------------------
  // Cell behaviour
  // ----------------------------------------------------------------
  // Programming can only pull bits low; erase sets them all high
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      if (wr_erase_in) begin
        mem[wr_addr_in] <= WORD_ERASED;
      end else begin
        mem[wr_addr_in] <= mem[wr_addr_in] & wr_data_in;
      end
    end
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : flash_array

`default_nettype wire

// >>> rtl/flash_seq.sv
`timescale 1ns/1ns
`default_nettype none

module flash_seq
  import flash_seq_pkg::*;
(
  input  wire logic              clock_in,          // System clock
  input  wire logic              rst_in,            // Async reset, high
  input  wire logic              fetch_req_in,      // Fetch read, hold
  input  wire logic [ADDR_W-1:0] fetch_addr_in,     // Fetch address
  output logic      [WORD_W-1:0] fetch_data_out,    // Fetch word
  output logic                   fetch_valid_out,   // Fetch word pulse
  input  wire logic              ind_req_in,        // Pointer read, hold
  input  wire logic [ADDR_W-1:0] ind_addr_in,       // Pointer address
  output logic      [WORD_W-1:0] ind_data_out,      // Pointer word
  output logic                   ind_valid_out,     // Pointer word pulse
  input  wire logic              nvm_read_in,       // Register read, hold
  input  wire logic [ADDR_W-1:0] nvm_addr_in,       // Register address
  input  wire logic [HIGH_W-1:0] nvm_data_high_in,  // Data high 6 bits
  input  wire logic [LOW_W-1:0]  nvm_data_low_in,   // Data low byte
  input  wire logic              nvm_latch_wr_in,   // Load one latch
  input  wire logic              nvm_write_in,      // Program row pulse
  input  wire logic              nvm_erase_in,      // Erase row pulse
  input  wire logic              nvm_bulk_in,       // Bulk request pulse
  output logic      [WORD_W-1:0] nvm_rdata_out,     // Register read word
  output logic                   nvm_rvalid_out,    // Register word pulse
  output logic                   nvm_error_out,     // Refused op pulse
  output logic                   busy_out,          // Operation running
  input  wire logic              pgm_read_in,       // Programmer read
  input  wire logic [ADDR_W-1:0] pgm_addr_in,       // Programmer address
  input  wire logic [WORD_W-1:0] pgm_data_in,       // Programmer word
  input  wire logic              pgm_write_in,      // Word write pulse
  input  wire logic              pgm_bulk_in,       // Bulk erase pulse
  input  wire logic              pgm_cfg_wr_in,     // Config write pulse
  input  wire logic [CFG_W-1:0]  pgm_cfg_data_in,   // Config bits
  output logic      [WORD_W-1:0] pgm_rdata_out,     // Programmer word
  output logic                   pgm_rvalid_out,    // Programmer pulse
  output logic                   pgm_error_out,     // Refused op pulse
  output logic                   eeprom_locked_out  // EEPROM closed
);

  // ----------------------------------------------------------------
  // Read arbitration
  // ----------------------------------------------------------------
  logic [SRC_N-1:0]  req, grant, pend_q, pend_d, issue_q, valid_q;
  logic [ADDR_W-1:0] raddr [SRC_N];
  logic [WORD_W-1:0] rdata_q [SRC_N];
  logic [WORD_W-1:0] rdata_d [SRC_N];
  logic [WORD_W-1:0] mem_rd;
  logic [ADDR_W-1:0] rd_addr;
  logic              code_lock;

  assign req   = {fetch_req_in, ind_req_in, nvm_read_in, pgm_read_in};
  assign raddr = '{pgm_addr_in, nvm_addr_in, ind_addr_in, fetch_addr_in};

  // One grant per cycle; a source waits for its request to drop
  always_comb begin
    grant   = '0;
    rd_addr = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (req[i] && !pend_q[i]) begin
        grant   = SRC_N'(1) << i;
        rd_addr = raddr[i];
      end
    end
    pend_d = grant | (pend_q & req);
  end

  // Per-source answer, programmer sees zeros while protected
  generate
    for (genvar g = 0; g < SRC_N; g++) begin : g_rd
      always_comb begin
        rdata_d[g] = rdata_q[g];
        if (issue_q[g]) begin
          rdata_d[g] = (g == SRC_PGM && code_lock) ? '0 : mem_rd;
        end
      end
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          rdata_q[g] <= '0;
        end else begin
          rdata_q[g] <= rdata_d[g];
        end
      end
    end
  endgenerate

  // Pipeline: grant, array register, answer register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q  <= '0;
      issue_q <= '0;
      valid_q <= '0;
    end else begin
      pend_q  <= pend_d;
      issue_q <= grant;
      valid_q <= issue_q;
    end
  end

  assign fetch_data_out  = rdata_q[SRC_FETCH];
  assign fetch_valid_out = valid_q[SRC_FETCH];
  assign ind_data_out    = rdata_q[SRC_IND];
  assign ind_valid_out   = valid_q[SRC_IND];
  assign nvm_rdata_out   = rdata_q[SRC_NVM];
  assign nvm_rvalid_out  = valid_q[SRC_NVM];
  assign pgm_rdata_out   = rdata_q[SRC_PGM];
  assign pgm_rvalid_out  = valid_q[SRC_PGM];

  // ----------------------------------------------------------------
  // Sequencer: latches, protection, timed erase and program
  // ----------------------------------------------------------------
  seq_state_e         state_q, state_d;
  op_e                op_q, op_d;
  logic [ADDR_W-1:0]  base_q, base_d, idx_q, idx_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic [WORD_W-1:0]  latch_q [ROW_WORDS];
  logic [WORD_W-1:0]  latch_d [ROW_WORDS];
  logic [WORD_W-1:0]  word_q, word_d;
  logic [ROW_WORDS-1:0] lvalid_q, lvalid_d;
  logic [CFG_W-1:0]   cfg_q, cfg_d;
  logic               nerr_d, perr_d, lock_d, wp_hit, fw_req;
  logic               wr_en, wr_erase;
  logic [ADDR_W-1:0]  wr_addr;
  logic [ROW_W-1:0]   slot;

  assign code_lock = !cfg_q[CFG_CODE_LOCK_BIT] || !cfg_q[CFG_DATA_LOCK_BIT];
  assign fw_req    = nvm_write_in || nvm_erase_in;
  assign slot      = idx_q[ROW_W-1:0];

  // Protected span follows the configured field
  always_comb begin
    case (cfg_q[CFG_WPROT_LSB +: 2])
      WP_OFF:     wp_hit = 1'b0;
      WP_QUARTER: wp_hit = nvm_addr_in < WP_QUARTER_END;
      WP_HALF:    wp_hit = nvm_addr_in < WP_HALF_END;
      default:    wp_hit = 1'b1;
    endcase
  end

  // Next-state logic; requests while busy are ignored
  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    base_d   = base_q;
    idx_d    = idx_q;
    timer_d  = timer_q;
    latch_d  = latch_q;
    word_d   = word_q;
    lvalid_d = lvalid_q;
    cfg_d    = cfg_q;
    nerr_d   = 1'b0;
    perr_d   = 1'b0;
    wr_en    = 1'b0;
    wr_erase = 1'b0;
    wr_addr  = {base_q[ADDR_W-1:ROW_W], slot};
    case (state_q)
      S_IDLE: begin
        if (nvm_latch_wr_in) begin
          latch_d[nvm_addr_in[ROW_W-1:0]] =
            {nvm_data_high_in, nvm_data_low_in};
          lvalid_d[nvm_addr_in[ROW_W-1:0]] = 1'b1;
        end
        if (pgm_cfg_wr_in) begin
          cfg_d = cfg_q & pgm_cfg_data_in;
        end
        idx_d = '0;
        if (pgm_bulk_in) begin
          op_d    = OP_BULK;
          timer_d = ERASE_CYCLES - 1'b1;
          state_d = S_TIME;
        end else if (pgm_write_in) begin
          if (code_lock) begin
            perr_d = 1'b1;
          end else begin
            op_d    = OP_WORD;
            base_d  = pgm_addr_in;
            word_d  = pgm_data_in;
            timer_d = WRITE_CYCLES - 1'b1;
            state_d = S_TIME;
          end
        end else if (nvm_bulk_in) begin
          nerr_d = 1'b1;
        end else if (fw_req && wp_hit) begin
          nerr_d = 1'b1;
        end else if (fw_req) begin
          op_d    = nvm_erase_in ? OP_ERASE : OP_PROG;
          base_d  = nvm_addr_in;
          timer_d = nvm_erase_in ? ERASE_CYCLES - 1'b1
                                 : WRITE_CYCLES - 1'b1;
          state_d = S_TIME;
        end
      end
      S_TIME: begin
        timer_d = timer_q - 1'b1;
        if (timer_q == '0) begin
          state_d = S_WORK;
        end
      end
      S_WORK: begin
        idx_d = idx_q + 1'b1;
        case (op_q)
          OP_ERASE: begin
            wr_en    = 1'b1;
            wr_erase = 1'b1;
            if (slot == ROW_LAST) state_d = S_IDLE;
          end
          OP_PROG: begin
            wr_en = lvalid_q[slot];
            if (slot == ROW_LAST) begin
              lvalid_d = '0;
              state_d  = S_IDLE;
            end
          end
          OP_WORD: begin
            wr_en   = 1'b1;
            wr_addr = base_q;
            state_d = S_IDLE;
          end
          default: begin
            wr_en    = 1'b1;
            wr_erase = 1'b1;
            wr_addr  = idx_q;
            if (idx_q == ADDR_LAST) begin
              cfg_d    = CFG_ERASED;
              lvalid_d = '0;
              state_d  = S_IDLE;
            end
          end
        endcase
      end
      default: state_d = S_IDLE;
    endcase
    lock_d = (cfg_d != CFG_ERASED) &&
             (!cfg_d[CFG_CODE_LOCK_BIT] || !cfg_d[CFG_DATA_LOCK_BIT]);
  end

  // Blank-device state at reset; config is erased
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q           <= S_IDLE;
      op_q              <= OP_ERASE;
      base_q            <= '0;
      idx_q             <= '0;
      timer_q           <= '0;
      latch_q           <= '{default: WORD_ERASED};
      word_q            <= WORD_ERASED;
      lvalid_q          <= '0;
      cfg_q             <= CFG_ERASED;
      nvm_error_out     <= 1'b0;
      pgm_error_out     <= 1'b0;
      busy_out          <= 1'b0;
      eeprom_locked_out <= 1'b0;
    end else begin
      state_q           <= state_d;
      op_q              <= op_d;
      base_q            <= base_d;
      idx_q             <= idx_d;
      timer_q           <= timer_d;
      latch_q           <= latch_d;
      word_q            <= word_d;
      lvalid_q          <= lvalid_d;
      cfg_q             <= cfg_d;
      nvm_error_out     <= nerr_d;
      pgm_error_out     <= perr_d;
      busy_out          <= state_d != S_IDLE;
      eeprom_locked_out <= lock_d;
    end
  end

  // Only the sequencer drives the write port
  flash_array u_array (
    .clock_in    (clock_in),
    .rd_en_in    (|grant),
    .rd_addr_in  (rd_addr),
    .rd_data_out (mem_rd),
    .wr_en_in    (wr_en),
    .wr_erase_in (wr_erase),
    .wr_addr_in  (wr_addr),
    .wr_data_in  (op_q == OP_WORD ? word_q : latch_q[slot])
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_read_one_word: assert property (grant[SRC_FETCH] |-> ##2
    fetch_valid_out ##1 !fetch_valid_out)
    else $error("fetch read did not give one word");
  a_erase_all_ones: assert property (wr_en && op_q != OP_WORD &&
    op_q != OP_PROG |-> wr_erase)
    else $error("erase write not all ones");
  a_prog_no_erase: assert property (wr_en && op_q == OP_PROG |->
    !wr_erase)
    else $error("program step erased a word");
  a_row_bound: assert property (wr_en && op_q == OP_ERASE |->
    wr_addr[ADDR_W-1:ROW_W] == base_q[ADDR_W-1:ROW_W])
    else $error("row erase left its row");
  a_latch_load: assert property (state_q == S_IDLE &&
    nvm_latch_wr_in |=> lvalid_q[$past(nvm_addr_in[ROW_W-1:0])])
    else $error("latch not loaded");
  a_timer_hold: assert property (state_q == S_IDLE &&
    state_d == S_TIME |=> busy_out [*8])
    else $error("operation not held by timer");
  a_pgm_read_zero: assert property (issue_q[SRC_PGM] &&
    code_lock |=> pgm_rdata_out == '0)
    else $error("protected word read out");
  a_fw_despite_lock: assert property (state_q == S_IDLE &&
    !pgm_bulk_in && !pgm_write_in && !nvm_bulk_in && fw_req &&
    !wp_hit |=> busy_out)
    else $error("firmware write blocked");
  a_lock_clear_bulk: assert property ($rose(cfg_q[CFG_CODE_LOCK_BIT])
    |-> $past(state_q) == S_WORK && $past(op_q) == OP_BULK)
    else $error("protection cleared without bulk erase");
  a_wp_refuse: assert property (state_q == S_IDLE && !pgm_bulk_in &&
    !pgm_write_in && fw_req && wp_hit |=> nvm_error_out && !busy_out)
    else $error("protected firmware write not refused");
  a_pgm_wp_free: assert property (state_q == S_IDLE && !pgm_bulk_in &&
    pgm_write_in && !code_lock |=> busy_out)
    else $error("programmer write blocked");
  a_no_fw_bulk: assert property (state_q == S_IDLE && !pgm_bulk_in &&
    !pgm_write_in && nvm_bulk_in |=> nvm_error_out && !busy_out)
    else $error("firmware bulk erase accepted");
  a_reads_only: assert property (wr_en |-> state_q == S_WORK)
    else $error("array written outside an operation");
  a_suppress_wp: assert property (nvm_error_out |->
    state_q == S_IDLE)
    else $error("refused request started an operation");

  c_row_erase: cover property (state_q == S_WORK && op_q == OP_ERASE
    && slot == ROW_LAST);
  c_row_prog: cover property (state_q == S_WORK && op_q == OP_PROG
    && slot == ROW_LAST);
  c_bulk_done: cover property ($rose(cfg_q[CFG_CODE_LOCK_BIT]));
  c_two_reads: cover property (fetch_valid_out && ind_req_in);

endmodule : flash_seq

`default_nettype wire

// >>> dv/programmer_model.sv
`timescale 1ns/1ns
`default_nettype none

module programmer_model
  import flash_seq_pkg::*;
(
  input  wire logic              clock_in,   // System clock
  input  wire logic [WORD_W-1:0] rdata_in,   // Word from device
  input  wire logic              rvalid_in,  // Word pulse
  output logic                   read_out,   // Read request, held
  output logic      [ADDR_W-1:0] addr_out,   // Word address
  output logic      [WORD_W-1:0] data_out,   // Word to write
  output logic                   write_out,  // Word write pulse
  output logic                   bulk_out,   // Bulk erase pulse
  output logic                   cfg_wr_out, // Config write pulse
  output logic      [CFG_W-1:0]  cfg_out     // Config bits
);
  // ----------------------------------------------------------------
  // Programmer side
  // ----------------------------------------------------------------
  // Idle lines at time zero
  initial begin
    {read_out, write_out, bulk_out, cfg_wr_out} = 4'h0;
    addr_out = 14'h0000;
    data_out = 14'h0000;
    cfg_out  = 4'hf;
  end

  // Held request; address flips after release so stale values never match
  task automatic read_word(input logic [ADDR_W-1:0] a,
                           output logic [WORD_W-1:0] d);
    int n;
    n = 0;
    read_out = 1'b1;
    addr_out = a;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (rvalid_in !== 1'b1 && n < 64);
    d = rdata_in;
    read_out = 1'b0;
    addr_out = ~a;
    @(posedge clock_in);
    #1;
  endtask : read_word

  // One-cycle pulse: 0 word write, 1 bulk erase, 2 config write
  task automatic pulse(input int kind, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d);
    addr_out = a;
    data_out = d;
    cfg_out  = d[CFG_W-1:0];
    write_out  = (kind == 0);
    bulk_out   = (kind == 1); // Only path that wipes protection
    cfg_wr_out = (kind == 2);
    @(posedge clock_in);
    #1;
    {write_out, bulk_out, cfg_wr_out} = 3'h0;
    data_out = ~d;
  endtask : pulse
endmodule : programmer_model

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import flash_seq_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in   = 1'b1;
  logic fetch_req_in = 1'b0, ind_req_in = 1'b0, nvm_read_in = 1'b0;
  logic [ADDR_W-1:0] fetch_addr_in = '0, ind_addr_in = '0, nvm_addr_in = '0;
  logic [HIGH_W-1:0] nvm_data_high_in = '0;
  logic [LOW_W-1:0]  nvm_data_low_in  = '0;
  logic nvm_latch_wr_in = 1'b0, nvm_write_in = 1'b0;
  logic nvm_erase_in = 1'b0, nvm_bulk_in = 1'b0;
  logic [WORD_W-1:0] fetch_data_out, ind_data_out, nvm_rdata_out;
  logic [WORD_W-1:0] pgm_rdata_out, pgm_data_in, got;
  logic fetch_valid_out, ind_valid_out, nvm_rvalid_out, nvm_error_out;
  logic busy_out, pgm_rvalid_out, pgm_error_out, eeprom_locked_out;
  logic pgm_read_in, pgm_write_in, pgm_bulk_in, pgm_cfg_wr_in;
  logic [ADDR_W-1:0] pgm_addr_in;
  logic [CFG_W-1:0]  pgm_cfg_data_in;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, instances, timeout
  // ----------------------------------------------------------------
  always #2 clock_in = ~clock_in;

  flash_seq dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .fetch_req_in(fetch_req_in), .fetch_addr_in(fetch_addr_in),
    .fetch_data_out(fetch_data_out), .fetch_valid_out(fetch_valid_out),
    .ind_req_in(ind_req_in), .ind_addr_in(ind_addr_in),
    .ind_data_out(ind_data_out), .ind_valid_out(ind_valid_out),
    .nvm_read_in(nvm_read_in), .nvm_addr_in(nvm_addr_in),
    .nvm_data_high_in(nvm_data_high_in), .nvm_data_low_in(nvm_data_low_in),
    .nvm_latch_wr_in(nvm_latch_wr_in), .nvm_write_in(nvm_write_in),
    .nvm_erase_in(nvm_erase_in), .nvm_bulk_in(nvm_bulk_in),
    .nvm_rdata_out(nvm_rdata_out), .nvm_rvalid_out(nvm_rvalid_out),
    .nvm_error_out(nvm_error_out), .busy_out(busy_out),
    .pgm_read_in(pgm_read_in), .pgm_addr_in(pgm_addr_in),
    .pgm_data_in(pgm_data_in), .pgm_write_in(pgm_write_in),
    .pgm_bulk_in(pgm_bulk_in), .pgm_cfg_wr_in(pgm_cfg_wr_in),
    .pgm_cfg_data_in(pgm_cfg_data_in), .pgm_rdata_out(pgm_rdata_out),
    .pgm_rvalid_out(pgm_rvalid_out), .pgm_error_out(pgm_error_out),
    .eeprom_locked_out(eeprom_locked_out));

  programmer_model prog_u (.clock_in(clock_in), .rdata_in(pgm_rdata_out),
    .rvalid_in(pgm_rvalid_out), .read_out(pgm_read_in),
    .addr_out(pgm_addr_in), .data_out(pgm_data_in),
    .write_out(pgm_write_in), .bulk_out(pgm_bulk_in),
    .cfg_wr_out(pgm_cfg_wr_in), .cfg_out(pgm_cfg_data_in));

  // Two bulk erases dominate the run, so the ceiling sits well above them
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [13:0] g, input logic [13:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask : tick

  // Firmware read; src 0 fetch, 1 pointer, 2 register interface
  task automatic fw_read(input int src, input logic [ADDR_W-1:0] a,
                         input logic [WORD_W-1:0] e);
    int n;
    n = 0;
    {fetch_addr_in, ind_addr_in, nvm_addr_in} = {a, a, a};
    fetch_req_in = (src == 0);
    ind_req_in   = (src == 1);
    nvm_read_in  = (src == 2);
    do begin
      tick();
      n++;
    end while (!(fetch_valid_out === 1'b1 || ind_valid_out === 1'b1 ||
                 nvm_rvalid_out === 1'b1) && n < 64);
    got = (src == 0) ? fetch_data_out :
          (src == 1) ? ind_data_out : nvm_rdata_out;
    {fetch_req_in, ind_req_in, nvm_read_in} = 3'h0;
    check(got, e);
    tick();
  endtask : fw_read

  // Firmware pulse: 0 latch load, 1 row program, 2 row erase, 3 bulk
  task automatic fw_op(input int kind, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d);
    nvm_addr_in = a;
    {nvm_data_high_in, nvm_data_low_in} = d;
    nvm_latch_wr_in = (kind == 0);
    nvm_write_in    = (kind == 1);
    nvm_erase_in    = (kind == 2);
    nvm_bulk_in     = (kind == 3);
    tick();
    {nvm_latch_wr_in, nvm_write_in, nvm_erase_in, nvm_bulk_in} = 4'h0;
  endtask : fw_op

  // Judge refusal, then time the busy level; negative length skips it
  task automatic op_done(input logic exp_err, input int exp_n);
    int n;
    n = 0;
    check(14'(nvm_error_out | pgm_error_out), 14'(exp_err));
    while (busy_out === 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    if (exp_n >= 0)
      check(14'(n), 14'(exp_n));
    tick();
  endtask : op_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_program();
    fw_op(2, 14'h0020, 14'h0000);
    op_done(1'b0, ERASE_CYCLES + ROW_WORDS);
    fw_op(0, 14'h0020, 14'h1a5c);
    tick();
    fw_op(0, 14'h0021, 14'h2bd3);
    tick();
    fw_op(1, 14'h0020, 14'h0000);
    op_done(1'b0, WRITE_CYCLES + ROW_WORDS);
    fw_read(2, 14'h0020, 14'h1a5c);
    fw_read(0, 14'h0021, 14'h2bd3);
    fw_read(1, 14'h0022, WORD_ERASED);
    fw_op(0, 14'h0020, 14'h0ff0);
    tick();
    fw_op(1, 14'h0020, 14'h0000);
    op_done(1'b0, WRITE_CYCLES + ROW_WORDS);
    fw_read(1, 14'h0020, 14'h1a5c & 14'h0ff0);
    fw_op(2, 14'h0025, 14'h0000);
    op_done(1'b0, ERASE_CYCLES + ROW_WORDS);
    fw_read(0, 14'h0020, WORD_ERASED);
    fw_op(3, 14'h0000, 14'h0000);
    op_done(1'b1, 0);
  endtask : t_program

  task automatic t_protect();
    prog_u.pulse(2, 14'h0000, 14'h000b);
    op_done(1'b0, -1);
    prog_u.pulse(0, 14'h0041, 14'h0a0a);
    op_done(1'b0, WRITE_CYCLES + 1);
    fw_op(2, 14'h0040, 14'h0000);
    op_done(1'b1, 0);
    fw_read(2, 14'h0041, 14'h0a0a);
    prog_u.pulse(2, 14'h0000, 14'h000a);
    op_done(1'b0, -1);
    check(14'(eeprom_locked_out), 14'h0001);
    prog_u.read_word(14'h0041, got);
    check(got, 14'h0000);
    prog_u.pulse(0, 14'h0042, 14'h0000);
    op_done(1'b1, 0);
    fw_op(2, WP_QUARTER_END, 14'h0000);
    op_done(1'b0, ERASE_CYCLES + ROW_WORDS);
    prog_u.pulse(1, 14'h0000, 14'h0000);
    op_done(1'b0, -1);
    check(14'(eeprom_locked_out), 14'h0000);
    prog_u.read_word(14'h0041, got);
    check(got, WORD_ERASED);
  endtask : t_protect

  // Half and whole spans; the data-protect bit alone also locks
  task automatic t_spans();
    prog_u.pulse(2, 14'h0000, 14'h0005);
    op_done(1'b0, -1);
    check(14'(eeprom_locked_out), 14'h0001);
    prog_u.pulse(0, 14'h0042, 14'h0000);
    op_done(1'b1, 0);
    fw_op(2, WP_QUARTER_END, 14'h0000);
    op_done(1'b1, 0);
    fw_op(2, WP_HALF_END, 14'h0000);
    op_done(1'b0, ERASE_CYCLES + ROW_WORDS);
    prog_u.pulse(2, 14'h0000, 14'h0001);
    op_done(1'b0, -1);
    fw_op(2, ADDR_LAST, 14'h0000);
    op_done(1'b1, 0);
  endtask : t_spans

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    check(14'(busy_out), 14'h0000);
    prog_u.pulse(1, 14'h0000, 14'h0000);
    op_done(1'b0, -1);
    t_program();
    t_protect();
    t_spans();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
